/* shared/ccs_pkg.sv */
// constants, types and register map of the clock source select / start-up block
// assumes one 250 MHz system clock and source clocks delivered as tick pulses
package ccs_pkg;

   // register byte offsets on the AHB-Lite slave
   localparam logic [7:0] CCS_OFF_SLEEP  = 8'h00;
   localparam logic [7:0] CCS_OFF_STATUS = 8'h04;
   localparam logic [7:0] CCS_OFF_PLL    = 8'h08;

   // clock source codes (fuse value as stored, 0 = programmed)
   localparam logic [3:0] CCS_SRC_EXT = 4'h0;
   localparam logic [3:0] CCS_SRC_PLL = 4'h1;
   localparam logic [3:0] CCS_SRC_RC  = 4'h2;

   // start-up counts in source clocks
   localparam logic [16:0] CCS_CK_RESET = 17'h0000E;   // 14 CK
   localparam logic [16:0] CCS_WAKE_6   = 17'h00006;
   localparam logic [16:0] CCS_WAKE_258 = 17'h00102;
   localparam logic [16:0] CCS_WAKE_1K  = 17'h00400;
   localparam logic [16:0] CCS_WAKE_16K = 17'h04000;
   // reset time-outs in watchdog oscillator cycles
   localparam logic [16:0] CCS_WDT_4K   = 17'h01000;
   localparam logic [16:0] CCS_WDT_64K  = 17'h10000;

   // watchdog time-out selection
   localparam logic [1:0] CCS_WDT_NONE  = 2'h0;
   localparam logic [1:0] CCS_WDT_SHORT = 2'h1;
   localparam logic [1:0] CCS_WDT_LONG  = 2'h2;

   // status register field positions
   localparam int CCS_ST_SUT   = 4;
   localparam int CCS_ST_DIV8  = 6;
   localparam int CCS_ST_RANGE = 7;
   localparam int CCS_ST_RSVD  = 10;
   localparam int CCS_ST_RUN   = 11;
   localparam int CCS_ST_STATE = 12;

   // reset values
   localparam logic [1:0] CCS_RST_SLEEP = 2'h0;
   localparam logic [1:0] CCS_RST_PLL   = 2'h0;

   typedef enum logic [1:0] {
      CCS_M_ACTIVE = 2'h0,
      CCS_M_IDLE   = 2'h1,
      CCS_M_NOISE  = 2'h2,
      CCS_M_DOWN   = 2'h3
   } ccs_mode_e;

   typedef enum logic [2:0] {
      CCS_S_FUSE  = 3'b000,
      CCS_S_CK14  = 3'b001,
      CCS_S_WDT   = 3'b011,
      CCS_S_RUN   = 3'b010,
      CCS_S_SLEEP = 3'b110,
      CCS_S_WAKE  = 3'b111,
      CCS_S_HALT  = 3'b101
   } ccs_state_e;

   typedef struct packed {
      logic       div8;
      logic [1:0] sut;
      logic [3:0] cksel;
   } ccs_fuse_s;

   // delivered state: RC oscillator, start-up code 10, divide by eight programmed
   localparam ccs_fuse_s CCS_FUSE_RST = '{div8: 1'b0, sut: 2'h2, cksel: 4'h2};

   typedef struct packed {
      logic core;
      logic io;
      logic flash;
      logic adc;
      logic pll;
   } ccs_gate_s;

endpackage

/* core/ccs_clock_source_select_startup.sv */
// clock source decode, start-up sequencing and clock domain gating
// assumes fuse levels, source ticks and wake events synchronous to clock
`timescale 1ns/1ns
module ccs_clock_source_select_startup #(
   parameter logic [16:0] WAKE_LONG_CK = ccs_pkg::CCS_WAKE_16K,
   parameter logic [16:0] WDT_SHORT_CK = ccs_pkg::CCS_WDT_4K,
   parameter logic [16:0] WDT_LONG_CK  = ccs_pkg::CCS_WDT_64K
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              rstn,
   // fuse levels
   input  wire ccs_pkg::ccs_fuse_s fuse_in,
   // source and watchdog oscillator ticks
   input  wire logic              xtal_tick,
   input  wire logic              ext_tick,
   input  wire logic              rc_tick,
   input  wire logic              pll_tick,
   input  wire logic              wdt_tick,
   // wake events
   input  wire logic              wake_event,
   input  wire logic              ext_int_async_event,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // domain clocks and status
   output logic                   core_clock,
   output logic                   peripheral_clock,
   output logic                   program_memory_clock,
   output logic                   converter_clock,
   output logic                   fast_pll_clock,
   output logic                   cpu_run,
   output logic                   sys_div8,
   output logic      [2:0]        oscillator_range_code,
   output logic      [3:0]        source_select
);
   import ccs_pkg::*;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   ccs_state_e      state_reg;
   ccs_state_e      state_next;
   ccs_fuse_s       fuse_reg;
   ccs_mode_e       mode_reg;
   ccs_gate_s       gate_reg;
   ccs_gate_s       gate_want;
   logic [16:0]     cnt_reg;
   logic [1:0]      pll_div_reg;
   logic [2:0]      pre_reg;
   logic            phase_reg;
   logic            pll_phase_reg;
   logic            pll_gate_reg;
   logic [1:0]      pll_ctl_reg;
   logic [7:0]      dp_addr_reg;
   logic            dp_wr_reg;
   logic [31:0]     hrdata_reg;
   logic            hreadyout_reg;
   logic            core_clock_reg;
   logic            peripheral_clock_reg;
   logic            program_memory_clock_reg;
   logic            converter_clock_reg;
   logic            fast_pll_clock_reg;
   logic            cpu_run_reg;
   logic            sys_div8_reg;
   logic [2:0]      range_reg;
   logic [3:0]      source_select_reg;

   // source decode from the sampled fuses
   wire             is_xtal   = fuse_reg.cksel[3];
   wire             is_pll    = (fuse_reg.cksel == CCS_SRC_PLL);
   wire             is_rc     = (fuse_reg.cksel == CCS_SRC_RC);
   wire             is_ext    = (fuse_reg.cksel == CCS_SRC_EXT);
   // reserved codes and reserved start-up code
   wire             src_valid = is_xtal | is_pll | is_rc | is_ext;
   wire             reserved  = !src_valid || (!is_xtal && fuse_reg.sut == 2'h3);
   wire [2:0]       st_idx    = {fuse_reg.cksel[0], fuse_reg.sut};

   // crystal table: index steps short, long, none in turn
   wire [1:0]       xtal_wdt  = (st_idx == 3'h0 || st_idx == 3'h3 || st_idx == 3'h6)
                                ? CCS_WDT_SHORT
                                : (st_idx == 3'h1 || st_idx == 3'h4 || st_idx == 3'h7)
                                ? CCS_WDT_LONG : CCS_WDT_NONE;
   // non-crystal sources: code 00 none, 01 short, 10 long
   wire [1:0]       wdt_sel   = is_xtal ? xtal_wdt : fuse_reg.sut;
   // wake start-up length in source clocks
   wire [16:0]      xtal_wake = (st_idx < 3'h2) ? CCS_WAKE_258
                                : (st_idx < 3'h5) ? CCS_WAKE_1K : WAKE_LONG_CK;
   wire [16:0]      wake_len  = is_xtal ? xtal_wake : CCS_WAKE_6;
   wire [16:0]      wake_last = 17'(wake_len - 17'h00001);
   wire [16:0]      wdt_last  = (wdt_sel == CCS_WDT_LONG)
                                ? 17'(WDT_LONG_CK - 17'h00001)
                                : 17'(WDT_SHORT_CK - 17'h00001);
   wire [16:0]      ck14_last = 17'(CCS_CK_RESET - 17'h00001);

   // PLL divided by four for the core source
   wire             pll_div4  = pll_tick && (pll_div_reg == 2'h3);
   wire             src_tick  = is_xtal ? xtal_tick : is_ext ? ext_tick
                                : is_rc ? rc_tick : is_pll ? pll_div4 : 1'b0;
   // programmed divide-by-eight fuse reads as zero
   wire             div8_on   = !fuse_reg.div8;
   wire             sys_tick  = src_tick && (!div8_on || pre_reg == 3'h0);

   // asynchronous external interrupt wakes even with I/O gated
   wire             wake_any  = wake_event | ext_int_async_event;

   // AHB-Lite address phase and data phase decode
   wire             ap_valid  = hsel && htrans[1] && hready;
   wire             word_ok   = (hsize == 3'h2);
   wire             wr_sleep  = dp_wr_reg && (dp_addr_reg == CCS_OFF_SLEEP);
   wire             wr_pll    = dp_wr_reg && (dp_addr_reg == CCS_OFF_PLL);
   wire             sleep_go  = wr_sleep && (hwdata[1:0] != CCS_M_ACTIVE)
                                && (state_reg == CCS_S_RUN);
   wire [31:0]      status_w  = {17'h00000, state_reg, cpu_run_reg, reserved,
                                 range_reg, div8_on, fuse_reg.sut, fuse_reg.cksel};
   wire [31:0]      rd_mux    = (haddr[7:0] == CCS_OFF_SLEEP)  ? {30'h0, mode_reg}
                              : (haddr[7:0] == CCS_OFF_STATUS) ? status_w
                              : (haddr[7:0] == CCS_OFF_PLL)    ? {30'h0, pll_ctl_reg}
                              : 32'h00000000;

   // start-up sequencer
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         CCS_S_FUSE:  state_next = CCS_S_CK14;
         CCS_S_CK14:
         begin
            if (reserved)
               state_next = CCS_S_HALT;
            else if (src_tick && cnt_reg == ck14_last)
               state_next = (wdt_sel == CCS_WDT_NONE) ? CCS_S_RUN : CCS_S_WDT;
         end
         CCS_S_WDT:
         begin
            if (wdt_tick && cnt_reg == wdt_last)
               state_next = CCS_S_RUN;
         end
         CCS_S_RUN:
         begin
            if (sleep_go)
               state_next = CCS_S_SLEEP;
         end
         CCS_S_SLEEP:
         begin
            if (wake_any)
               state_next = (mode_reg == CCS_M_DOWN) ? CCS_S_WAKE : CCS_S_RUN;
         end
         CCS_S_WAKE:
         begin
            if (src_tick && cnt_reg == wake_last)
               state_next = CCS_S_RUN;
         end
         CCS_S_HALT:  state_next = CCS_S_HALT;
         default:     state_next = CCS_S_HALT;
      endcase
   end

   // domain enables per state and sleep mode
   always_comb
   begin
      gate_want = '0;
      if (state_reg == CCS_S_RUN)
         gate_want = '{core: 1'b1, io: 1'b1, flash: 1'b1, adc: 1'b1, pll: pll_ctl_reg[0]};
      else if (state_reg == CCS_S_SLEEP)
      begin
         gate_want.io    = (mode_reg == CCS_M_IDLE);
         gate_want.adc   = (mode_reg != CCS_M_DOWN);
         gate_want.pll   = pll_ctl_reg[0] && (mode_reg != CCS_M_DOWN);
      end
   end

   // delivered fuses in reset, caught once after release, then frozen
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         fuse_reg <= CCS_FUSE_RST;
      else if (state_reg == CCS_S_FUSE)
         fuse_reg <= fuse_in;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg <= CCS_S_FUSE;
         cnt_reg   <= '0;
      end
      else
      begin
         state_reg <= state_next;
         if (state_next != state_reg)
            cnt_reg <= '0;
         else if ((state_reg == CCS_S_WDT) ? wdt_tick : src_tick)
            cnt_reg <= 17'(cnt_reg + 17'h00001);
      end
   end

   // PLL divider, prescaler and domain clock phases
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         pll_div_reg   <= '0;
         pre_reg       <= '0;
         phase_reg     <= 1'b0;
         pll_phase_reg <= 1'b0;
      end
      else
      begin
         if (pll_tick)
            pll_div_reg <= 2'(pll_div_reg + 2'h1);
         if (src_tick)
            pre_reg <= 3'(pre_reg + 3'h1);
         if (sys_tick && state_reg != CCS_S_HALT)
            phase_reg <= !phase_reg;
         // 64 MHz toggles every PLL tick, 32 MHz every other one
         if (pll_tick && (pll_ctl_reg[1] || pll_div_reg[0]))
            pll_phase_reg <= !pll_phase_reg;
      end
   end

   // enables only move while the phase is low, so no runt pulse
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         gate_reg     <= '0;
         pll_gate_reg <= 1'b0;
      end
      else
      begin
         if (!phase_reg)
            gate_reg <= gate_want;
         if (!pll_phase_reg)
            pll_gate_reg <= gate_want.pll;
      end
   end

   // registered domain clocks and status outputs
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         core_clock_reg           <= 1'b0;
         peripheral_clock_reg     <= 1'b0;
         program_memory_clock_reg <= 1'b0;
         converter_clock_reg      <= 1'b0;
         fast_pll_clock_reg       <= 1'b0;
         cpu_run_reg              <= 1'b0;
         sys_div8_reg             <= 1'b0;
         range_reg                <= '0;
         source_select_reg        <= '0;
      end
      else
      begin
         core_clock_reg           <= phase_reg && gate_reg.core;
         peripheral_clock_reg     <= phase_reg && gate_reg.io;
         program_memory_clock_reg <= phase_reg && gate_reg.flash;
         converter_clock_reg      <= phase_reg && gate_reg.adc;
         fast_pll_clock_reg       <= pll_phase_reg && pll_gate_reg;
         cpu_run_reg              <= (state_next == CCS_S_RUN);
         sys_div8_reg             <= div8_on;
         // range only meaningful in crystal mode
         range_reg                <= is_xtal ? fuse_reg.cksel[3:1] : 3'h0;
         source_select_reg        <= {is_xtal, is_pll, is_rc, is_ext};
      end
   end

   // AHB-Lite slave: zero wait states, always OKAY, unmapped reads zero
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         dp_addr_reg <= '0;
         dp_wr_reg   <= 1'b0;
         hrdata_reg  <= '0;
         mode_reg    <= CCS_M_ACTIVE;
         pll_ctl_reg <= CCS_RST_PLL;
         hreadyout_reg <= 1'b0;
      end
      else
      begin
         // ready one edge after release, then never stalls
         hreadyout_reg <= 1'b1;
         if (hready)
         begin
            dp_addr_reg <= haddr[7:0];
            dp_wr_reg   <= ap_valid && hwrite && word_ok;
         end
         if (ap_valid && !hwrite)
            hrdata_reg <= rd_mux;
         if (wr_sleep)
            mode_reg <= ccs_mode_e'(hwdata[1:0]);
         if (wr_pll)
            pll_ctl_reg <= hwdata[1:0];
      end
   end

   assign hrdata                = hrdata_reg;
   assign hreadyout             = hreadyout_reg;
   assign hresp                 = 1'b0;
   assign core_clock            = core_clock_reg;
   assign peripheral_clock      = peripheral_clock_reg;
   assign program_memory_clock  = program_memory_clock_reg;
   assign converter_clock       = converter_clock_reg;
   assign fast_pll_clock        = fast_pll_clock_reg;
   assign cpu_run               = cpu_run_reg;
   assign sys_div8              = sys_div8_reg;
   assign oscillator_range_code = range_reg;
   assign source_select         = source_select_reg;

   // checks on decode, sequencing and gating
   property p_rc_select;
      (state_reg != CCS_S_FUSE && fuse_reg.cksel == CCS_SRC_RC) |=> source_select == 4'b0010;
   endproperty
   a_rc_select: assert property (p_rc_select) else $error("rc code not decoded");

   property p_reserved_halt;
      (state_reg == CCS_S_CK14 && !src_valid) |=> (state_reg == CCS_S_HALT) [*3] ##0 !cpu_run;
   endproperty
   a_reserved_halt: assert property (p_reserved_halt) else $error("reserved code ran");

   property p_div8;
      (state_reg != CCS_S_FUSE && !fuse_reg.div8) |=> sys_div8;
   endproperty
   a_div8: assert property (p_div8) else $error("programmed div8 not seen");

   property p_wake_hold;
      (state_reg == CCS_S_WAKE) |-> !core_clock_reg && !cpu_run_reg;
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("core ran during wake");

   property p_wdt_end;
      (state_reg == CCS_S_WDT && wdt_tick && cnt_reg == wdt_last) |=> cpu_run && state_reg == CCS_S_RUN;
   endproperty
   a_wdt_end: assert property (p_wdt_end) else $error("reset delay did not end");

   property p_wdt_skip;
      (state_reg == CCS_S_CK14 && wdt_sel == CCS_WDT_NONE) |=> state_reg != CCS_S_WDT;
   endproperty
   a_wdt_skip: assert property (p_wdt_skip) else $error("needless watchdog delay");

   property p_first_fuse;
      (state_reg == CCS_S_FUSE) |-> fuse_reg == CCS_FUSE_RST;
   endproperty
   a_first_fuse: assert property (p_first_fuse) else $error("delivered value lost");

   property p_range;
      (state_reg != CCS_S_FUSE && is_xtal) |=> oscillator_range_code == $past(fuse_reg.cksel[3:1]);
   endproperty
   a_range: assert property (p_range) else $error("range code wrong");

   property p_flash_follows;
      program_memory_clock == core_clock;
   endproperty
   a_flash_follows: assert property (p_flash_follows) else $error("flash clock split");

   property p_glitch_free;
      (gate_reg != $past(gate_reg)) |-> !$past(phase_reg);
   endproperty
   a_glitch_free: assert property (p_glitch_free) else $error("gate moved while high");

   c_wake_down: cover property (state_reg == CCS_S_WAKE ##1 state_reg == CCS_S_RUN);
   c_wdt_run:   cover property (state_reg == CCS_S_WDT ##1 state_reg == CCS_S_RUN);
   c_halt:      cover property (state_reg == CCS_S_HALT);
endmodule

/* verif/ccs_osc_model.sv */
// far-side model: crystal or resonator, external driver, rc, pll and watchdog oscillators
// assumes the block samples one-cycle tick pulses at the rising system clock edge
`timescale 1ns/1ns
module ccs_osc_model #(
   parameter int SRC_PER = 2,
   parameter int PLL_PER = 2,
   parameter int WDT_PER = 5
) (
   // system clock
   input  wire logic clock,
   // oscillator ticks
   output logic      xtal_tick,
   output logic      ext_tick,
   output logic      rc_tick,
   output logic      pll_tick,
   output logic      wdt_tick
);
   int src_cnt = 0;
   int pll_cnt = 0;
   int wdt_cnt = 0;

   // oscillators run free from power-up; reset of the block does not stop them
   always_ff @(posedge clock)
   begin
      src_cnt <= (src_cnt == SRC_PER - 1) ? 0 : src_cnt + 1;
      pll_cnt <= (pll_cnt == PLL_PER - 1) ? 0 : pll_cnt + 1;
      wdt_cnt <= (wdt_cnt == WDT_PER - 1) ? 0 : wdt_cnt + 1;
   end

   // one pulse per oscillator edge; crystal, external and rc sources share a rate to keep delays easy to predict
   assign xtal_tick = (src_cnt == 0);
   assign ext_tick  = (src_cnt == 0);
   assign rc_tick   = (src_cnt == 0);
   assign pll_tick  = (pll_cnt == 0);
   assign wdt_tick  = (wdt_cnt == 0);
endmodule

/* verif/testbench.sv */
// self-checking bench for clock source select, start-up delays and domain gating
// assumes the oscillator model supplies all source and watchdog ticks
`timescale 1ns/1ns
module testbench;
   import ccs_pkg::*;
   localparam int SP = 2;   // source tick period in cycles
   localparam int PP = 2;   // pll tick period in cycles
   localparam int WP = 5;   // watchdog tick period in cycles
   logic        clock, rstn, hsel, hwrite, wake_event, ext_int_async_event;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, oscillator_range_code;
   ccs_fuse_s   fuse_in;
   logic        xtal_tick, ext_tick, rc_tick, pll_tick, wdt_tick, hreadyout, hresp;
   logic        core_clock, peripheral_clock, program_memory_clock, converter_clock;
   logic        fast_pll_clock, cpu_run, sys_div8;
   logic [3:0]  source_select;
   logic [4:0]  tg;
   logic [4:0]  gates;
   int          bad_count, samples_checked, n, pc;

   // domain clocks as one vector {core, io, flash, adc, pll}
   assign gates = {core_clock, peripheral_clock, program_memory_clock, converter_clock,
                   fast_pll_clock};

   // small counts keep the long crystal and watchdog delays short
   ccs_clock_source_select_startup #(.WAKE_LONG_CK(17'h00014), .WDT_SHORT_CK(17'h00008),
      .WDT_LONG_CK(17'h00010)) u_ccs_clock_source_select_startup (.clock(clock),
      .rstn(rstn), .fuse_in(fuse_in), .xtal_tick(xtal_tick), .ext_tick(ext_tick),
      .rc_tick(rc_tick), .pll_tick(pll_tick), .wdt_tick(wdt_tick), .wake_event(wake_event),
      .ext_int_async_event(ext_int_async_event), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .core_clock(core_clock), .peripheral_clock(peripheral_clock),
      .program_memory_clock(program_memory_clock), .converter_clock(converter_clock),
      .fast_pll_clock(fast_pll_clock), .cpu_run(cpu_run), .sys_div8(sys_div8),
      .oscillator_range_code(oscillator_range_code), .source_select(source_select));

   ccs_osc_model #(.SRC_PER(SP), .PLL_PER(PP), .WDT_PER(WP)) u_ccs_osc_model (
      .clock(clock), .xtal_tick(xtal_tick), .ext_tick(ext_tick), .rc_tick(rc_tick),
      .pll_tick(pll_tick), .wdt_tick(wdt_tick));

   // 250 MHz system clock
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic results();
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %0t %s got %0h expected %0h", $time, m, got, exp);
      end
   endtask

   task automatic rng(input int got, input int lo, input int hi, input string m);
      samples_checked++;
      if (got < lo || got > hi)
      begin
         bad_count++;
         $display("ERROR %0t %s took %0d cycles, window %0d..%0d", $time, m, got, lo, hi);
      end
   endtask

   // waits for hready high at a rising edge; only the hang guard ends a stuck wait
   task automatic edge_ready();
      do
         @(posedge clock);
      while (hreadyout !== 1'b1);
   endtask

   // one single AHB-Lite transfer; read data taken at the data-phase edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic [2:0] sz, output logic [31:0] rdat);
      @(posedge clock);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      hsize  <= sz;
      edge_ready();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      edge_ready();
      rdat = hrdata;
   endtask

   // reset with given fuses, then count cycles until execution starts
   task automatic boot(input logic d8, input logic [1:0] s, input logic [3:0] c);
      @(posedge clock);
      rstn    <= 1'b0;
      fuse_in <= '{div8: d8, sut: s, cksel: c};
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      n = 0;
      while (cpu_run !== 1'b1 && n < 600)
      begin
         @(posedge clock);
         n++;
      end
   endtask

   // records which domain clocks moved over 80 cycles
   task automatic watch(output logic [4:0] t);
      logic [4:0] p;
      t = 5'h00;
      p = gates;
      repeat (80)
      begin
         @(posedge clock);
         t = t | (p ^ gates);
         p = gates;
      end
   endtask

   task automatic pcount(output int c);
      logic p;
      c = 0;
      p = fast_pll_clock;
      repeat (40)
      begin
         @(posedge clock);
         c = c + int'(p != fast_pll_clock);
         p = fast_pll_clock;
      end
   endtask

   // enter a sleep mode, check the gating, wake and count cycles to run
   task automatic nap(input logic [1:0] m, input logic [4:0] expg, input logic via_ext);
      ahb(1'b1, CCS_OFF_SLEEP, {30'h0, m}, 3'h2, rd);
      repeat (40) @(posedge clock);
      chk(cpu_run, 1'b0, "cpu_run in sleep");
      watch(tg);
      chk(tg, expg, "sleep gating");
      wake_event          <= ~via_ext;
      ext_int_async_event <= via_ext;
      @(posedge clock);
      wake_event          <= 1'b0;
      ext_int_async_event <= 1'b0;
      n = 0;
      while (cpu_run !== 1'b1 && n < 3000)
      begin
         @(posedge clock);
         n++;
      end
   endtask

   function automatic logic [3:0] src_of(input logic [3:0] c);
      return c[3] ? 4'h8 : (c == 4'h1) ? 4'h4 : (c == 4'h2) ? 4'h2 : (c == 4'h0) ? 4'h1 : 4'h0;
   endfunction

   // one clock option: reset delay, decode, status and power-down wake count
   task automatic cfg(input logic [3:0] c, input logic [1:0] s, input int nw, input int wk,
                      input int sp);
      int         e;
      logic [2:0] r;
      r = c[3] ? c[3:1] : 3'h0;
      boot(1'b1, s, c);
      e = 14 * sp + nw * WP;
      // watchdog tick phase may shorten the span by up to one watchdog period
      rng(n, e - sp - ((nw > 0) ? WP : 0), e + sp + 12, "reset delay");
      chk(source_select, src_of(c), "source decode");
      chk(oscillator_range_code, r, "oscillator range");
      chk(sys_div8, 1'b0, "divider off");
      ahb(1'b0, CCS_OFF_STATUS, 32'h0, 3'h2, rd);
      chk(rd[14:0], {3'h2, 1'b1, 1'b0, r, 1'b0, s, c}, "status");
      nap(2'h3, 5'h00, 1'b0);
      e = wk * sp;
      rng(n, e - sp, e + sp + 12, "wake delay");
   endtask

   // hang guard, far beyond the expected run length
   initial
   begin
      repeat (100000) @(posedge clock);
      bad_count++;
      $display("ERROR %0t watchdog expired", $time);
      results();
   end

   initial
   begin
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      wake_event = 1'b0;
      ext_int_async_event = 1'b0;
      fuse_in = '{div8: 1'b0, sut: 2'h2, cksel: 4'h2};
      bad_count = 0;
      samples_checked = 0;
      boot(1'b0, 2'h2, 4'h2);
      rng(n, 14 * SP + 16 * WP - SP - WP, 14 * SP + 16 * WP + SP + 12, "shipped delay");
      chk(sys_div8, 1'b1, "divide by eight");
      ahb(1'b0, CCS_OFF_STATUS, 32'h0, 3'h2, rd);
      chk(rd[14:0], 15'h2862, "shipped status");
      chk({hreadyout, hresp}, 2'b10, "ready and okay");
      ahb(1'b1, CCS_OFF_STATUS, 32'hFFFF, 3'h2, rd);
      ahb(1'b0, CCS_OFF_STATUS, 32'h0, 3'h2, rd);
      chk(rd[14:0], 15'h2862, "status read only");
      ahb(1'b1, 8'h0C, 32'hFFFF, 3'h2, rd);
      ahb(1'b0, 8'h0C, 32'h0, 3'h2, rd);
      chk(rd, 32'h0, "unmapped read");
      ahb(1'b1, CCS_OFF_PLL, 32'h3, 3'h0, rd);
      ahb(1'b0, CCS_OFF_PLL, 32'h0, 3'h2, rd);
      chk(rd, 32'h0, "byte write ignored");
      watch(tg);
      chk(tg, 5'h1E, "run gating, pll off");
      ahb(1'b1, CCS_OFF_PLL, 32'h3, 3'h2, rd);
      repeat (20) @(posedge clock);
      pcount(pc);
      rng(pc, 19, 21, "fast pll rate");
      ahb(1'b1, CCS_OFF_PLL, 32'h1, 3'h2, rd);
      repeat (20) @(posedge clock);
      pcount(pc);
      rng(pc, 9, 11, "slow pll rate");
      nap(2'h1, 5'h0B, 1'b1);
      rng(n, 0, 3, "idle wake");
      nap(2'h2, 5'h03, 1'b0);
      rng(n, 0, 3, "noise wake");
      nap(2'h3, 5'h00, 1'b0);
      rng(n, 6 * SP - SP, 6 * SP + SP + 12, "rc wake");
      cfg(4'h0, 2'h1, 8, 6, SP);
      cfg(4'h1, 2'h0, 0, 6, 4 * PP);
      cfg(4'h2, 2'h1, 8, 6, SP);
      cfg(4'h8, 2'h0, 8, 258, SP);
      cfg(4'hA, 2'h1, 16, 258, SP);
      cfg(4'hC, 2'h2, 0, 1024, SP);
      cfg(4'hC, 2'h3, 8, 1024, SP);
      cfg(4'hD, 2'h0, 16, 1024, SP);
      cfg(4'hF, 2'h1, 0, 20, SP);
      cfg(4'hF, 2'h2, 8, 20, SP);
      cfg(4'hF, 2'h3, 16, 20, SP);
      // reserved source codes never run
      for (int c = 3; c < 8; c++)
      begin
         boot(1'b1, 2'h0, c[3:0]);
         chk(cpu_run, 1'b0, "reserved runs");
         chk(source_select, 4'h0, "reserved decode");
         ahb(1'b0, CCS_OFF_STATUS, 32'h0, 3'h2, rd);
         chk(rd[14:12], 3'h5, "reserved state");
      end
      boot(1'b1, 2'h3, 4'h2);
      chk(cpu_run, 1'b0, "rc code 11 runs");
      results();
   end
endmodule
